/* File: core/cia_ack_split.sv */
// Acknowledge register and priority split point of one processor interface
// Notes on behaviour
// - 3-bit split divides priority into group, sub
// - Split writes clamp to minimum; reset loads minimum
// - Lower priority value means more urgent
// - Secure accesses reach non-secure split via alias
// - Acknowledge word: id [9:0], core [12:10]
// - Core field is requesting interface number, binary
// - Core field zero for non-software interrupts
// - One acknowledge register for both security states
// - Acknowledge read returns top pending id
// - Returns 1023 when disabled or nothing sufficient
// - Request drops when source leaves; read gives 1023
// - Secure mismatch gives 1023, or 1022 without ack control
// - Valid acknowledge moves to active or active-pending
// - Pending kept only for asserted level source
// - Shared interrupt may reach several readers; software locks
module cia_ack_split (
    // Clock and reset
    input  wire logic                                        mclk,
    input  wire logic                                        rst,
    // Register port
    input  wire logic [7:0]                                  regAddr,
    input  wire logic [31:0]                                 regWdata,
    input  wire logic                                        regWr,
    input  wire logic                                        regRd,
    input  wire logic                                        regSecure,
    output logic      [31:0]                                 regRdata,
    // Distributor side
    input  wire logic [cia_pkg::NUM_IRQ-1:0]                 irqPending,
    input  wire logic [cia_pkg::NUM_IRQ*cia_pkg::PRIO_W-1:0] irqPriority,
    input  wire logic [cia_pkg::NUM_IRQ-1:0]                 irqSecure,
    input  wire logic [cia_pkg::NUM_IRQ-1:0]                 irqLevelHigh,
    input  wire logic [cia_pkg::NUM_SGI*cia_pkg::CORE_W-1:0] sgiSourceCore,
    // Priority context from mask and running priority logic
    input  wire logic [cia_pkg::PRIO_W-1:0]                  priorityMask,
    input  wire logic [cia_pkg::PRIO_W-1:0]                  runningPriority,
    // Acknowledge effect towards the distributor
    output logic                                             ackStrobe,
    output logic      [cia_pkg::ID_W-1:0]                    ackId,
    output logic                                             ackStillPending,
    // Processor request and event interrupt
    output logic                                             cpuIrqReq,
    output logic                                             eventIrq
);
    // Winner of the pending scan
    logic                         bestValid;
    logic [cia_pkg::ID_W-1:0]     bestId;
    logic [cia_pkg::PRIO_W-1:0]   bestPrio;
    logic                         bestSecure;

    // Control and split state
    logic [1:0]                   ctrl_r, ctrl_nxt;          // Enable, ack control
    logic [2:0]                   splitSec_r, splitSec_nxt;  // Secure copy
    logic [2:0]                   splitNs_r, splitNs_nxt;    // Non-secure copy
    logic [1:0]                   evtStat_r, evtStat_nxt;    // Sticky events
    logic [1:0]                   evtMask_r, evtMask_nxt;    // Event mask
    // Read and acknowledge outputs
    logic [31:0]                  rdata_r, rdata_nxt;
    logic                         ackStrobe_r, ackStrobe_nxt;
    logic [cia_pkg::ID_W-1:0]     ackId_r, ackId_nxt;
    logic                         ackPend_r, ackPend_nxt;
    logic                         irqReq_r, irqReq_nxt;

    // Decision helpers
    logic [2:0]                   splitUsed;      // Split applied to the winner
    logic                         sufficient;     // Winner may be signalled
    logic [cia_pkg::ID_W-1:0]     answerId;       // Id an acknowledge would see
    logic [cia_pkg::CORE_W-1:0]   answerCore;     // Source core an acknowledge sees
    logic                         answerValid;    // Answer is a real interrupt
    logic                         ackRead;        // Acknowledge read this cycle

    // Clamp a written split value to the implementation minimum
    function automatic logic [2:0] clampSplit(input logic [2:0] v);
        clampSplit = (v < cia_pkg::SPLIT_MIN) ? cia_pkg::SPLIT_MIN : v;
    endfunction : clampSplit

    // Group part of a priority: bits above the split point
    function automatic logic [7:0] groupOf(input logic [7:0] prio, input logic [2:0] split);
        logic [3:0] keep;
        keep    = 4'(split) + 4'h1;
        groupOf = prio & (8'hFF << keep);
    endfunction : groupOf

    // Pending scan
    cia_top_finder u_finder (
        .irqPending  (irqPending),
        .irqPriority (irqPriority),
        .irqSecure   (irqSecure),
        .bestValid   (bestValid),
        .bestId      (bestId),
        .bestPrio    (bestPrio),
        .bestSecure  (bestSecure)
    );

    // Sufficiency and the answer an acknowledge read would return
    always_comb begin
        // Each security state preempts by its own split copy
        splitUsed  = bestSecure ? splitSec_r : splitNs_r;
        // Below the mask and preempting the running group
        sufficient = ctrl_r[cia_pkg::CTRL_EN_BIT] && bestValid &&
                     (bestPrio < priorityMask) &&
                     (groupOf(bestPrio, splitUsed) <
                      groupOf(runningPriority, splitUsed));
        answerId    = cia_pkg::ID_SPURIOUS;
        answerCore  = '0;
        answerValid = 1'b0;
        if (!sufficient) begin
            // Disabled or nothing worth signalling
            answerId = cia_pkg::ID_SPURIOUS;
        end else if (bestSecure && !regSecure) begin
            // Non-secure reader must not see a secure id
            answerId = cia_pkg::ID_SPURIOUS;
        end else if (!bestSecure && regSecure && !ctrl_r[cia_pkg::CTRL_SECURE_ACK_OF_NONSECURE_CTRL_BIT]) begin
            // Secure reader told a non-secure one waits
            answerId = cia_pkg::ID_SEC_ONLY;
        end else begin
            answerId    = bestId;
            answerValid = 1'b1;
            // Source core only for software irqs
            if (bestId < cia_pkg::ID_W'(cia_pkg::NUM_SGI)) begin
                answerCore = sgiSourceCore[bestId[3:0]*cia_pkg::CORE_W +: cia_pkg::CORE_W];
            end else begin
                answerCore = '0;
            end
        end
    end

    // Same acknowledge offset for both security states, no banking
    assign ackRead = regRd && (regAddr == cia_pkg::ACK_OFS);

    // Register writes, clear-on-read events and read data
    always_comb begin
        ctrl_nxt     = ctrl_r;
        splitSec_nxt = splitSec_r;
        splitNs_nxt  = splitNs_r;
        evtMask_nxt  = evtMask_r;
        evtStat_nxt  = evtStat_r;
        rdata_nxt    = '0;
        if (regWr) begin
            unique case (regAddr)
                cia_pkg::CTRL_OFS: begin
                    ctrl_nxt = regWdata[1:0];
                end
                cia_pkg::SPLIT_OFS: begin
                    // Banked by the security of the access
                    if (regSecure) begin
                        splitSec_nxt = clampSplit(regWdata[2:0]);
                    end else begin
                        splitNs_nxt = clampSplit(regWdata[2:0]);
                    end
                end
                cia_pkg::ALIAS_SPLIT_OFS: begin
                    // Alias lets a secure-only core set non-secure grouping
                    if (regSecure) begin
                        splitNs_nxt = clampSplit(regWdata[2:0]);
                    end
                end
                cia_pkg::EVT_MASK_OFS: begin
                    evtMask_nxt = regWdata[1:0];
                end
                default: begin
                    // Acknowledge and status are read only
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                cia_pkg::CTRL_OFS: begin
                    rdata_nxt = {30'h0, ctrl_r};
                end
                cia_pkg::SPLIT_OFS: begin
                    rdata_nxt = {29'h0, regSecure ? splitSec_r : splitNs_r};
                end
                cia_pkg::ALIAS_SPLIT_OFS: begin
                    rdata_nxt = regSecure ? {29'h0, splitNs_r} : 32'h0;
                end
                cia_pkg::ACK_OFS: begin
                    rdata_nxt = {19'h0, answerCore, answerId};
                end
                cia_pkg::EVT_STAT_OFS: begin
                    rdata_nxt   = {30'h0, evtStat_r};
                    evtStat_nxt = 2'h0;
                end
                cia_pkg::EVT_MASK_OFS: begin
                    rdata_nxt = {30'h0, evtMask_r};
                end
                default: begin
                    rdata_nxt = 32'h0;
                end
            endcase
        end
        // New events set after the clear, so a same-cycle event survives
        if (ackRead && answerValid) begin
            evtStat_nxt[cia_pkg::EVT_VALID_BIT] = 1'b1;
        end
        if (ackRead && !answerValid) begin
            evtStat_nxt[cia_pkg::EVT_SPUR_BIT] = 1'b1;
        end
    end

    // Acknowledge side effect and the processor request
    always_comb begin
        ackStrobe_nxt = 1'b0;
        ackId_nxt     = ackId_r;
        ackPend_nxt   = ackPend_r;
        // Level follows sufficiency, so a withdrawn source drops it
        irqReq_nxt    = sufficient;
        if (ackRead && answerValid) begin
            // Tell the distributor: pending to active
            ackStrobe_nxt = 1'b1;
            ackId_nxt     = answerId;
            // Still-asserted level source stays pending as well
            ackPend_nxt   = irqLevelHigh[bestId[4:0]];
            // Drop the request at once so the core does not see it twice
            irqReq_nxt    = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r      <= cia_pkg::CTRL_RESET;
            splitSec_r  <= cia_pkg::SPLIT_MIN;
            splitNs_r   <= cia_pkg::SPLIT_MIN;
            evtStat_r   <= cia_pkg::EVT_RESET;
            evtMask_r   <= cia_pkg::EVT_RESET;
            rdata_r     <= 32'h0;
            ackStrobe_r <= 1'b0;
            ackId_r     <= '0;
            ackPend_r   <= 1'b0;
            irqReq_r    <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            splitSec_r  <= splitSec_nxt;
            splitNs_r   <= splitNs_nxt;
            evtStat_r   <= evtStat_nxt;
            evtMask_r   <= evtMask_nxt;
            rdata_r     <= rdata_nxt;
            ackStrobe_r <= ackStrobe_nxt;
            ackId_r     <= ackId_nxt;
            ackPend_r   <= ackPend_nxt;
            irqReq_r    <= irqReq_nxt;
        end
    end

    // Outputs; shared interrupts may be handed to several cores, no lock here
    assign regRdata        = rdata_r;
    assign ackStrobe       = ackStrobe_r;
    assign ackId           = ackId_r;
    assign ackStillPending = ackPend_r;
    assign cpuIrqReq       = irqReq_r;
    assign eventIrq        = |(evtStat_r & evtMask_r);
endmodule : cia_ack_split

/* File: include/cia_pkg.sv */
// Constants and register map for the processor acknowledge block
package cia_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0]  CTRL_OFS        = 8'h00;  // Control: enable, ack control
    localparam logic [7:0]  SPLIT_OFS       = 8'h08;  // priority_split_point
    localparam logic [7:0]  ACK_OFS         = 8'h0C;  // interrupt_acknowledge
    localparam logic [7:0]  EVT_STAT_OFS    = 8'h10;  // Event status, clear on read
    localparam logic [7:0]  EVT_MASK_OFS    = 8'h14;  // Event mask
    localparam logic [7:0]  ALIAS_SPLIT_OFS = 8'h1C;  // aliased_nonsecure_split_point
    // Sizes
    localparam int          NUM_IRQ         = 32;     // Sources handled here
    localparam int          NUM_SGI         = 16;     // IDs below this are software irqs
    localparam int          ID_W            = 10;     // Interrupt number width
    localparam int          PRIO_W          = 8;      // Priority width
    localparam int          CORE_W          = 3;      // Source core field width
    // Acknowledge word layout
    localparam int          ACK_ID_LSB      = 0;      // acknowledged_irq_number [9:0]
    localparam int          ACK_CORE_LSB    = 10;     // source_core_number [12:10]
    // Split point field
    localparam int          SPLIT_W         = 3;      // Field [2:0]
    localparam logic [2:0]  SPLIT_MIN       = 3'h2;   // Implementation minimum, reset value
    // Control register bits
    localparam int          CTRL_EN_BIT     = 0;      // Signalling enable
    localparam int          CTRL_SECURE_ACK_OF_NONSECURE_CTRL_BIT = 1;      // secure_ack_of_nonsecure_ctrl
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    // Event bits
    localparam int          EVT_VALID_BIT   = 0;      // Valid acknowledge taken
    localparam int          EVT_SPUR_BIT    = 1;      // Spurious id returned
    localparam logic [1:0]  EVT_RESET       = 2'h0;
    // Special identifiers
    localparam logic [9:0]  ID_SPURIOUS     = 10'h3FF; // 1023
    localparam logic [9:0]  ID_SEC_ONLY     = 10'h3FE; // 1022
endpackage : cia_pkg

/* File: core/cia_top_finder.sv */
// Finds the most urgent pending interrupt among all sources
module cia_top_finder (
    // Source state
    input  wire logic [cia_pkg::NUM_IRQ-1:0]                irqPending,
    input  wire logic [cia_pkg::NUM_IRQ*cia_pkg::PRIO_W-1:0] irqPriority,
    input  wire logic [cia_pkg::NUM_IRQ-1:0]                irqSecure,
    // Winner
    output logic                                            bestValid,
    output logic      [cia_pkg::ID_W-1:0]                   bestId,
    output logic      [cia_pkg::PRIO_W-1:0]                 bestPrio,
    output logic                                            bestSecure
);
    // Linear scan; lowest value wins, lowest id breaks ties
    always_comb begin
        bestValid  = 1'b0;
        bestId     = '0;
        bestPrio   = '1;
        bestSecure = 1'b0;
        for (int i = 0; i < cia_pkg::NUM_IRQ; i++) begin
            // Strictly lower value is higher priority; keeps earlier id on ties
            if (irqPending[i] && (!bestValid ||
                irqPriority[i*cia_pkg::PRIO_W +: cia_pkg::PRIO_W] < bestPrio)) begin
                bestValid  = 1'b1;
                bestId     = cia_pkg::ID_W'(i);
                bestPrio   = irqPriority[i*cia_pkg::PRIO_W +: cia_pkg::PRIO_W];
                bestSecure = irqSecure[i];
            end
        end
    end
endmodule : cia_top_finder

/* File: dv/cia_ack_checker_properties.sv */
// Port-level properties of the acknowledge and split point block
module cia_ack_checker (
    // Clock, reset and register port
    input wire logic                        mclk,
    input wire logic                        rst,
    input wire logic [7:0]                  regAddr,
    input wire logic                        regRd,
    input wire logic [31:0]                 regRdata,
    // Sources and acknowledge results
    input wire logic [cia_pkg::NUM_IRQ-1:0] irqPending,
    input wire logic                        ackStrobe,
    input wire logic [cia_pkg::ID_W-1:0]    ackId,
    input wire logic                        cpuIrqReq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Strobe only follows a read of the acknowledge word
    property p_ackCause; ackStrobe |-> $past(regRd) && $past(regAddr) == cia_pkg::ACK_OFS; endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack strobe without ack read");
    // Returned number matches the one handed to the distributor
    property p_ackWord; ackStrobe |-> regRdata[9:0] == ackId && regRdata[31:13] == 19'h0; endproperty
    a_ackWord: assert property (p_ackWord) else $error("ack word layout wrong");
    property p_sgiCore; ackStrobe && ackId >= 10'(cia_pkg::NUM_SGI) |-> regRdata[12:10] == 3'h0;
    endproperty
    a_sgiCore: assert property (p_sgiCore) else $error("core field set for non-software irq");
    // Spurious answers must not acknowledge anything
    property p_spurQuiet; regRd && regAddr == cia_pkg::ACK_OFS ##1 regRdata[9:1] == 9'h1FF
        |-> !ackStrobe; endproperty
    a_spurQuiet: assert property (p_spurQuiet) else $error("spurious read acknowledged");
    property p_noPend; regRd && regAddr == cia_pkg::ACK_OFS && irqPending == '0
        |=> regRdata[9:0] == cia_pkg::ID_SPURIOUS; endproperty
    a_noPend: assert property (p_noPend) else $error("empty ack read not 1023");
    // Read data only in the cycle after a read
    property p_idleZero; !$past(regRd) |-> regRdata == 32'h0; endproperty
    a_idleZero: assert property (p_idleZero) else $error("read data outside read slot");
    property p_split; regRd && regAddr == cia_pkg::SPLIT_OFS
        |=> regRdata[31:3] == '0 && regRdata[2:0] >= cia_pkg::SPLIT_MIN; endproperty
    a_split: assert property (p_split) else $error("split point below minimum");
    // Request falls one cycle after the sources go quiet
    property p_reqQuiet; irqPending == '0 |=> !cpuIrqReq; endproperty
    a_reqQuiet: assert property (p_reqQuiet) else $error("request with nothing pending");
    c_sgiAck: cover property (ackStrobe && ackId < 10'(cia_pkg::NUM_SGI));
    c_spur: cover property (regRd && regAddr == cia_pkg::ACK_OFS ##1 regRdata[9:0] == 10'h3FE);
    c_req: cover property ($rose(cpuIrqReq));
endmodule : cia_ack_checker

bind cia_ack_split cia_ack_checker u_chk (.mclk, .rst, .regAddr, .regRd, .regRdata,
    .irqPending, .ackStrobe, .ackId, .cpuIrqReq);

/* File: dv/cia_dist_model.sv */
// Distributor-side pending model facing the acknowledge block
module cia_dist_model (
    // Clock and reset
    input wire logic                        mclk,
    input wire logic                        rst,
    // Bench requests to raise or drop sources
    input wire logic [cia_pkg::NUM_IRQ-1:0] setPend,
    input wire logic [cia_pkg::NUM_IRQ-1:0] clrPend,
    // Acknowledge effect
    input wire logic                        ackStrobe,
    input wire logic [cia_pkg::ID_W-1:0]    ackId,
    input wire logic                        ackStillPending,
    // Completion written back by the processor
    input wire logic                        eoiWr,
    input wire logic [31:0]                 eoiWord,
    // Pending and active state
    output logic     [cia_pkg::NUM_IRQ-1:0] irqPending,
    output logic     [cia_pkg::NUM_IRQ-1:0] irqActive
);
    timeunit 1ns;
    timeprecision 1ps;
    // Acknowledge turns a source active; an asserted level source stays pending
    always_ff @(posedge mclk) begin
        if (rst) begin
            irqPending <= '0;
        end else begin
            irqPending <= (irqPending | setPend) & ~clrPend
                & ~((ackStrobe && !ackStillPending) ? (32'h1 << ackId) : 32'h0);
        end
    end
    // Acknowledge makes a source active; the returned completion word ends it
    always_ff @(posedge mclk) begin
        if (rst) begin
            irqActive <= '0;
        end else begin
            irqActive <= (irqActive | (ackStrobe ? (32'h1 << ackId) : 32'h0))
                & ~(eoiWr ? (32'h1 << eoiWord[9:0]) : 32'h0);
        end
    end
endmodule : cia_dist_model

/* File: dv/cia_ack_split_tb.sv */
// Self-checking bench for the acknowledge and split point block
module cia_ack_split_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, regSecure = 1'b0;
    logic [7:0]   regAddr = 8'h00, priorityMask = 8'hFF, runningPriority = 8'hFF;
    logic [31:0]  regWdata = 32'h0, regRdata, setPend = 32'h0, clrPend = 32'h0, irqPending;
    logic [31:0]  irqSecure = 32'h0, irqLevelHigh = 32'h0;
    logic [255:0] irqPriority = '1;   // All sources idle at lowest urgency
    logic [47:0]  sgiSourceCore = 48'h0;
    logic         eoiWr = 1'b0;
    logic [31:0]  eoiWord = 32'h0, irqActive;
    logic         ackStrobe, ackStillPending, cpuIrqReq, eventIrq;
    logic [9:0]   ackId;
    int           numErrors = 0, checked = 0, cycles = 0;
    always #2.5 mclk = ~mclk;
    cia_ack_split u_dut (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regSecure, .regRdata,
        .irqPending, .irqPriority, .irqSecure, .irqLevelHigh, .sgiSourceCore, .priorityMask,
        .runningPriority, .ackStrobe, .ackId, .ackStillPending, .cpuIrqReq, .eventIrq);
    cia_dist_model u_dist (.mclk, .rst, .setPend, .clrPend, .ackStrobe, .ackId, .ackStillPending,
        .eoiWr, .eoiWord, .irqPending, .irqActive);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One-cycle write; extra edge keeps strobes from colliding
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s);
        regAddr <= a;
        regWdata <= d;
        regSecure <= s;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic s, output logic [31:0] d);
        regAddr <= a;
        regSecure <= s;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge mclk);
    endtask : rd
    task automatic regChk(input logic [7:0] a, input logic s, input logic [31:0] e);
        logic [31:0] d;
        rd(a, s, d);
        chk("register", e, d);
    endtask : regChk
    // Acknowledge read; a valid id is completed by writing back the word as read
    task automatic ack(input logic s, input logic [31:0] w, input logic a);
        logic [31:0] d;
        regAddr <= cia_pkg::ACK_OFS;
        regSecure <= s;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 d = regRdata;
        chk("ackword", w, d);
        chk("ackstrobe", {31'h0, a}, {31'h0, ackStrobe});
        if (a) begin
            chk("ackid", {22'h0, w[9:0]}, {22'h0, ackId});
        end
        @(posedge mclk);
        // Spurious ids need no completion
        if (d[9:1] != 9'h1FF) begin
            eoiWord <= d;
            eoiWr <= 1'b1;
            @(posedge mclk);
            eoiWr <= 1'b0;
        end
    endtask : ack
    // Flag sampled once settled, then realign to the edge
    task automatic flag(input string n, input logic e);
        #1 chk(n, {31'h0, e}, {31'h0, (n == "irqreq") ? cpuIrqReq : eventIrq});
        @(posedge mclk);
    endtask : flag
    task automatic pend(input logic [31:0] s, input logic [31:0] c);
        setPend <= s;
        clrPend <= c;
        @(posedge mclk);
        setPend <= 32'h0;
        clrPend <= 32'h0;
        repeat (2) @(posedge mclk);
    endtask : pend
    task automatic testRegs();
        regChk(cia_pkg::SPLIT_OFS, 1'b1, {29'h0, cia_pkg::SPLIT_MIN});
        wr(cia_pkg::SPLIT_OFS, 32'h0, 1'b0);
        regChk(cia_pkg::SPLIT_OFS, 1'b0, {29'h0, cia_pkg::SPLIT_MIN});
        wr(cia_pkg::SPLIT_OFS, 32'hFFFF_FFFF, 1'b1);
        regChk(cia_pkg::SPLIT_OFS, 1'b1, 32'h7);
        wr(cia_pkg::ALIAS_SPLIT_OFS, 32'h5, 1'b1);
        wr(cia_pkg::ALIAS_SPLIT_OFS, 32'h7, 1'b0);
        regChk(cia_pkg::SPLIT_OFS, 1'b0, 32'h5);
        regChk(cia_pkg::ALIAS_SPLIT_OFS, 1'b0, 32'h0);
        regChk(8'h40, 1'b1, 32'h0);
        wr(cia_pkg::SPLIT_OFS, 32'h2, 1'b0);
        wr(cia_pkg::SPLIT_OFS, 32'h2, 1'b1);
    endtask : testRegs
    task automatic testAck();
        irqPriority[8*5 +: 8] <= 8'h40;
        irqPriority[8*9 +: 8] <= 8'h30;
        irqPriority[8*20 +: 8] <= 8'h30;
        sgiSourceCore[3*5 +: 3] <= 3'h3;
        sgiSourceCore[3*9 +: 3] <= 3'h1;
        pend(32'h0010_0220, 32'h0);
        ack(1'b0, 32'h3FF, 1'b0);
        wr(cia_pkg::CTRL_OFS, 32'h1, 1'b0);
        flag("irqreq", 1'b1);
        ack(1'b0, 32'h0409, 1'b1);
        ack(1'b0, 32'h0014, 1'b1);
        #1 chk("stillpend", 32'h0, {31'h0, ackStillPending});
        @(posedge mclk);
        irqLevelHigh[5] <= 1'b1;
        ack(1'b0, 32'h0C05, 1'b1);
        #1 chk("stillpend", 32'h1, {31'h0, ackStillPending});
        @(posedge mclk);
        irqLevelHigh[5] <= 1'b0;
        pend(32'h0, 32'h20);
        flag("irqreq", 1'b0);
        ack(1'b0, 32'h3FF, 1'b0);
    endtask : testAck
    task automatic testMask();
        pend(32'h0010_0000, 32'h0);
        priorityMask <= 8'h30;
        ack(1'b0, 32'h3FF, 1'b0);
        priorityMask <= 8'hFF;
        runningPriority <= 8'h34;
        ack(1'b0, 32'h3FF, 1'b0);
        runningPriority <= 8'h38;
        ack(1'b0, 32'h0014, 1'b1);
        runningPriority <= 8'hFF;
    endtask : testMask
    task automatic testSec();
        irqSecure[20] <= 1'b1;
        irqPriority[8*21 +: 8] <= 8'h50;
        pend(32'h0010_0000, 32'h0);
        ack(1'b0, 32'h3FF, 1'b0);
        ack(1'b1, 32'h0014, 1'b1);
        pend(32'h0020_0000, 32'h0);
        ack(1'b1, 32'h3FE, 1'b0);
        wr(cia_pkg::CTRL_OFS, 32'h3, 1'b1);
        ack(1'b1, 32'h0015, 1'b1);
    endtask : testSec
    task automatic testEvent();
        wr(cia_pkg::EVT_MASK_OFS, 32'h3, 1'b0);
        flag("eventirq", 1'b1);
        regChk(cia_pkg::EVT_STAT_OFS, 1'b0, 32'h3);
        flag("eventirq", 1'b0);
    endtask : testEvent
    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : printVerdict
    // Hang guard, far beyond the hundred or so cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            numErrors++;
            printVerdict();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        testRegs();
        testAck();
        testMask();
        testSec();
        testEvent();
        // Every valid acknowledge must have been completed by now
        chk("active", 32'h0, irqActive);
        printVerdict();
    end
endmodule : cia_ack_split_tb
